// file: core_model.sv
/*
  Core model: 16-bit register store and a byte source with stalls.
  Assumes the bench seeds the random generator.
*/
`timescale 1ns/100ps
module core_model (
  // Clock
  input  wire logic        clk_i,
  // Register strobes
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  output logic [15:0]      reg_rdata_o,
  // Byte stream
  output logic             rx_byte_valid_o,
  input  wire logic        rx_byte_ready_i,
  output logic [7:0]       rx_byte_o
);
  logic [15:0] regs_r [256];
  logic [7:0]  q [$];

  // Only sixteen bits are kept, so nothing above lane 15 comes back.
  assign reg_rdata_o = regs_r[reg_addr_i];

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  always @(posedge clk_i) begin
    if (reg_we_i === 1'b1) regs_r[reg_addr_i] <= reg_wdata_i;
    if (rx_byte_valid_o && rx_byte_ready_i === 1'b1) begin
      void'(q.pop_front());
      rx_byte_valid_o <= 1'b0;
      // A stale byte is inverted so that it can never pass for data.
      rx_byte_o <= ~rx_byte_o;
    end
  end

  // Bytes go out in the order pushed and are held until taken.
  always @(negedge clk_i) begin
    if (!rx_byte_valid_o && q.size() > 0 && $urandom_range(3) != 0) begin
      rx_byte_valid_o = 1'b1;
      rx_byte_o = q[0];
    end
  end
endmodule

// file: host_lanes_properties.sv
/*
  Port checker for host_port_lanes, bound to every instance of it.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module host_lanes_chk #(
  parameter logic [15:0] DEVICE_NUMBER = 16'h5A01
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // Straps and host bus
  input wire logic        bus_mux_select_strap_i,
  input wire logic        wide_bus_strap_i,
  input wire logic        byte_order_strap_i,
  input wire logic        host_ale_i,
  input wire logic        host_req_i,
  input wire logic        host_we_i,
  input wire logic [7:0]  host_addr_i,
  input wire logic [31:0] host_wdata_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic        host_ack_o,
  input wire logic        mux_mode_o,
  input wire logic        wide_mode_o,
  input wire logic        little_mode_o,
  // Core side
  input wire logic [15:0] reg_wdata_o,
  input wire logic        reg_we_o,
  input wire logic        reg_re_o,
  input wire logic [15:0] reg_rdata_i
);
  logic       busy_r;
  logic [7:0] ale_r;
  logic [7:0] adr;
  logic       acc;

  // In multiplexed mode the address comes from the latch phase.
  assign adr = mux_mode_o ? ale_r : host_addr_i;
  assign acc = host_req_i && (!busy_r || host_ack_o);

  always_ff @(posedge clk_i) begin
    if (srst_i) busy_r <= 1'b0;
    else if (acc) busy_r <= 1'b1;
    else if (host_ack_o) busy_r <= 1'b0;
    if (host_ale_i) ale_r <= host_wdata_i[7:0];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_reg;
    acc && adr != 8'hFE && adr != 8'h00;
  endsequence
  sequence s_read_back;
    reg_re_o ##1 host_rdata_o == {16'h0000, $past(reg_rdata_i)};
  endsequence

  property p_reg_ack;
    acc && adr != 8'hFE |-> ##2 host_ack_o;
  endproperty
  property p_write;
    s_reg ##0 host_we_i |=> reg_we_o &&
      {16'h0000, reg_wdata_o} == ($past(host_wdata_i) & 32'h0000FFFF);
  endproperty
  property p_read;
    s_reg ##0 !host_we_i |=> s_read_back;
  endproperty
  property p_devnum;
    acc && adr == 8'h00 && !host_we_i |->
      ##2 host_rdata_o == {16'h0000, DEVICE_NUMBER};
  endproperty
  property p_queue;
    acc && adr == 8'hFE && !host_we_i |=> !host_ack_o && !reg_re_o;
  endproperty
  property p_qwrite;
    acc && adr == 8'hFE && host_we_i |=> host_ack_o && !reg_we_o;
  endproperty
  property p_narrow;
    host_ack_o && !wide_mode_o |-> host_rdata_o[31:16] == 16'h0000;
  endproperty
  property p_hold;
    !$past(srst_i) |-> $stable({mux_mode_o, wide_mode_o, little_mode_o});
  endproperty
  property p_capture;
    disable iff (1'b0) srst_i |=> mux_mode_o == $past(bus_mux_select_strap_i)
      && wide_mode_o == $past(wide_bus_strap_i)
      && little_mode_o == $past(byte_order_strap_i);
  endproperty

  a_reg_ack: assert property (p_reg_ack)
    else $error("register access not acked two cycles on");
  a_write: assert property (p_write)
    else $error("register write lanes wrong");
  a_read: assert property (p_read)
    else $error("register read data wrong");
  a_devnum: assert property (p_devnum)
    else $error("device number read wrong");
  a_queue: assert property (p_queue)
    else $error("queue read answered too early");
  a_qwrite: assert property (p_qwrite)
    else $error("queue write not acked in the next cycle");
  a_narrow: assert property (p_narrow)
    else $error("upper lanes driven on narrow bus");
  a_hold: assert property (p_hold)
    else $error("captured mode changed outside reset");
  a_capture: assert property (p_capture)
    else $error("mode does not follow strap in reset");
endmodule

bind host_port_lanes host_lanes_chk #(
  .DEVICE_NUMBER(DEVICE_NUMBER)
) chk_u (.*);

// file: host_port_lanes.sv
/*
  Parallel host port configuration and byte-lane logic: strap capture,
  register path on the low 16 lanes, and queue byte packing into words.
  Assumes a host bus already reduced to single-cycle request pulses and a
  core register port that answers reads in the same cycle as the strobe.
*/
`timescale 1ns/100ps
module host_port_lanes #(
  parameter int unsigned    FIFO_DEPTH    = host_port_pkg::FIFO_DEPTH,
  parameter logic [15:0]    DEVICE_NUMBER = host_port_pkg::DEVICE_NUMBER_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Configuration straps
  input  wire logic        bus_mux_select_strap_i,
  input  wire logic        wide_bus_strap_i,
  input  wire logic        byte_order_strap_i,
  // Host bus
  input  wire logic        host_ale_i,
  input  wire logic        host_req_i,
  input  wire logic        host_we_i,
  input  wire logic [7:0]  host_addr_i,
  input  wire logic [31:0] host_wdata_i,
  output logic [31:0]      host_rdata_o,
  output logic             host_ack_o,
  // Captured configuration
  output logic             mux_mode_o,
  output logic             wide_mode_o,
  output logic             little_mode_o,
  // Core register port
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  output logic             reg_we_o,
  output logic             reg_re_o,
  input  wire logic [15:0] reg_rdata_i,
  // Receive byte stream from the core
  input  wire logic        rx_byte_valid_i,
  output logic             rx_byte_ready_o,
  input  wire logic [7:0]  rx_byte_i
);

  // The FIFO wraps its pointers, so its depth must be a power of two.
  if (FIFO_DEPTH < 2 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("host_port_lanes: FIFO_DEPTH must be a power of two >= 2");
  end

  // Lane geometry is fixed: four lanes fill the bus, two a register.
  if (host_port_pkg::LANES_WIDE * host_port_pkg::BYTE_W !=
      host_port_pkg::BUS_W ||
      host_port_pkg::LANES_NARROW * host_port_pkg::BYTE_W !=
      host_port_pkg::REG_W) begin : g_lane_chk
    $error("host_port_lanes: lane counts do not match the bus widths");
  end

  // Index of the last byte of a queue word on each bus width.
  localparam logic [1:0] LAST_WIDE   = 2'(host_port_pkg::LANES_WIDE - 1);
  localparam logic [1:0] LAST_NARROW = 2'(host_port_pkg::LANES_NARROW - 1);

  function automatic logic [1:0] last_lane(input logic wide);
    last_lane = wide ? LAST_WIDE : LAST_NARROW;
  endfunction

  // Address decodes shared by the request path.
  function automatic logic is_devnum(input logic [7:0] addr);
    is_devnum = (addr == host_port_pkg::DEVNUM_ADDR);
  endfunction

  function automatic logic is_queue(input logic [7:0] addr);
    is_queue = (addr == host_port_pkg::QUEUE_ADDR);
  endfunction

  // Lane that byte k of a word occupies for the given straps.
  function automatic logic [1:0] lane_of(input logic [1:0] k,
                                         input logic       wide,
                                         input logic       little);
    logic [1:0] top;
    top = last_lane(wide);
    if (little) begin
      lane_of = k;
    end else begin
      lane_of = top - k;
    end
  endfunction

  // Straps.
  logic mux_mode;
  logic wide_mode;
  logic little_mode;

  host_strap_capture u_strap (
    .clk_i                  (clk_i),
    .srst_i                 (srst_i),
    .bus_mux_select_strap_i (bus_mux_select_strap_i),
    .wide_bus_strap_i       (wide_bus_strap_i),
    .byte_order_strap_i     (byte_order_strap_i),
    .mux_mode_o             (mux_mode),
    .wide_mode_o            (wide_mode),
    .little_mode_o          (little_mode)
  );

  assign mux_mode_o    = mux_mode;
  assign wide_mode_o   = wide_mode;
  assign little_mode_o = little_mode;

  // Queue byte packer.
  logic [1:0]  bcnt_r;
  logic [1:0]  bcnt_nxt;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic [31:0] merged;
  logic [1:0]  lane;
  logic [1:0]  last_idx;
  logic        last_byte;
  logic        byte_take;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [31:0] fifo_out_data;

  assign last_idx  = last_lane(wide_mode);
  assign last_byte = (bcnt_r == last_idx);
  assign lane      = lane_of(bcnt_r, wide_mode, little_mode);
  // A full FIFO stalls the source only on the byte that completes a word.
  assign rx_byte_ready_o = !last_byte || fifo_in_ready;
  assign byte_take       = rx_byte_valid_i && rx_byte_ready_o;
  assign fifo_in_valid   = rx_byte_valid_i && last_byte;

  always_comb begin
    merged = acc_r;
    for (int i = 0; i < host_port_pkg::LANES_WIDE; i++) begin
      if (lane == 2'(i)) begin
        merged[i*8 +: 8] = rx_byte_i;
      end
    end
    bcnt_nxt = bcnt_r;
    acc_nxt  = acc_r;
    if (byte_take) begin
      if (last_byte) begin
        bcnt_nxt = 2'h0;
        acc_nxt  = 32'h0000_0000;
      end else begin
        bcnt_nxt = bcnt_r + 2'h1;
        acc_nxt  = merged;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bcnt_r <= 2'h0;
      acc_r  <= 32'h0000_0000;
    end else begin
      bcnt_r <= bcnt_nxt;
      acc_r  <= acc_nxt;
    end
  end

  // Four words of slack let the core keep streaming while the host is busy.
  host_word_fifo #(
    .WIDTH (host_port_pkg::BUS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (merged),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Host access sequencer.
  host_port_pkg::acc_state_t state_r;
  host_port_pkg::acc_state_t state_nxt;
  logic [7:0]  ale_addr_r;
  logic [7:0]  ale_addr_nxt;
  logic [7:0]  req_addr;
  logic [7:0]  raddr_r;
  logic [7:0]  raddr_nxt;
  logic [15:0] rwdata_r;
  logic [15:0] rwdata_nxt;
  logic        rwe_r;
  logic        rwe_nxt;
  logic        rre_r;
  logic        rre_nxt;
  logic        devnum_r;
  logic        devnum_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        ack_r;
  logic        ack_nxt;

  // The multiplexed bus carries the address on the data lanes at ALE.
  assign req_addr = mux_mode ? ale_addr_r : host_addr_i;
  assign fifo_out_ready = (state_r == host_port_pkg::ST_QWAIT);

  always_comb begin
    state_nxt    = state_r;
    ale_addr_nxt = ale_addr_r;
    raddr_nxt    = raddr_r;
    rwdata_nxt   = rwdata_r;
    rwe_nxt      = 1'b0;
    rre_nxt      = 1'b0;
    devnum_nxt   = devnum_r;
    rdata_nxt    = rdata_r;
    ack_nxt      = 1'b0;
    if (mux_mode && host_ale_i) begin
      ale_addr_nxt = host_wdata_i[7:0];
    end
    case (state_r)
      host_port_pkg::ST_IDLE: begin
        if (host_req_i) begin
          if (is_queue(req_addr)) begin
            if (host_we_i) begin
              // Host-to-device queue words are not unpacked; acked, dropped.
              ack_nxt = 1'b1;
            end else begin
              state_nxt = host_port_pkg::ST_QWAIT;
            end
          end else begin
            raddr_nxt  = req_addr;
            // Upper lanes are dropped; no swap whatever the byte order.
            rwdata_nxt = host_wdata_i[15:0];
            devnum_nxt = is_devnum(req_addr);
            // The device number is read only; writes to it are dropped.
            rwe_nxt    = host_we_i && !is_devnum(req_addr);
            rre_nxt    = !host_we_i && !is_devnum(req_addr);
            state_nxt  = host_port_pkg::ST_REG;
          end
        end
      end
      host_port_pkg::ST_REG: begin
        // Writes refresh rdata as well; only reads are meant to use it.
        rdata_nxt = {host_port_pkg::UPPER_ZERO,
                     devnum_r ? DEVICE_NUMBER : reg_rdata_i};
        ack_nxt   = 1'b1;
        state_nxt = host_port_pkg::ST_IDLE;
      end
      host_port_pkg::ST_QWAIT: begin
        if (fifo_out_valid) begin
          // Words are packed at capture time, so the host sees them as is.
          rdata_nxt = fifo_out_data;
          ack_nxt   = 1'b1;
          state_nxt = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r    <= host_port_pkg::ST_IDLE;
      ale_addr_r <= 8'h00;
      raddr_r    <= 8'h00;
      rwdata_r   <= 16'h0000;
      rwe_r      <= 1'b0;
      rre_r      <= 1'b0;
      devnum_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      ack_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      ale_addr_r <= ale_addr_nxt;
      raddr_r    <= raddr_nxt;
      rwdata_r   <= rwdata_nxt;
      rwe_r      <= rwe_nxt;
      rre_r      <= rre_nxt;
      devnum_r   <= devnum_nxt;
      rdata_r    <= rdata_nxt;
      ack_r      <= ack_nxt;
    end
  end

  assign reg_addr_o   = raddr_r;
  assign reg_wdata_o  = rwdata_r;
  assign reg_we_o     = rwe_r;
  assign reg_re_o     = rre_r;
  // In narrow mode queue words only fill lanes 15..0, upper stay zero.
  assign host_rdata_o = rdata_r;
  assign host_ack_o   = ack_r;

endmodule

// file: host_port_pkg.sv
/*
  Shared constants for the parallel host port byte-lane logic.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package host_port_pkg;

  // Byte and word geometry.
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BUS_W       = 32;
  localparam int unsigned REG_W       = 16;
  localparam int unsigned LANES_NARROW = 2;
  localparam int unsigned LANES_WIDE  = 4;
  localparam int unsigned FIFO_DEPTH  = 4;

  // Host address map, 8-bit word addresses.
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  DEVNUM_ADDR = 8'h00;
  localparam logic [7:0]  QUEUE_ADDR  = 8'hFE;

  // Device number value; arbitrary, not tied to any part.
  localparam logic [15:0] DEVICE_NUMBER_DEF = 16'h5A01;

  // Upper half of a register read.
  localparam logic [15:0] UPPER_ZERO = 16'h0000;

  // Host access sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_REG   = 2'b01,
    ST_QWAIT = 2'b10
  } acc_state_t;

endpackage

// file: host_strap_capture.sv
/*
  Captures the three configuration straps while reset is held and
  freezes them at reset release. Assumes straps are synchronous to clk_i.
*/
`timescale 1ns/100ps
module host_strap_capture (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Strap pins
  input  wire logic bus_mux_select_strap_i,
  input  wire logic wide_bus_strap_i,
  input  wire logic byte_order_strap_i,
  // Captured settings
  output logic      mux_mode_o,
  output logic      wide_mode_o,
  output logic      little_mode_o
);

  logic [2:0] strap_r;
  logic [2:0] strap_nxt;

  // Following the pins while in reset makes the last sample the one at
  // the release edge; afterwards the pins are never looked at again.
  always_comb begin
    strap_nxt = strap_r;
    if (srst_i) begin
      strap_nxt = {bus_mux_select_strap_i, wide_bus_strap_i,
                   byte_order_strap_i};
    end
  end

  always_ff @(posedge clk_i) begin
    strap_r <= strap_nxt;
  end

  assign mux_mode_o    = strap_r[2];
  assign wide_mode_o   = strap_r[1];
  assign little_mode_o = strap_r[0];

endmodule

// file: host_word_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module host_word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 ||
      WIDTH < 1) begin : g_param_chk
    $error("host_word_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0]      wptr_r;
  logic [PW:0]      wptr_nxt;
  logic [PW:0]      rptr_r;
  logic [PW:0]      rptr_nxt;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full  = (wptr_r[PW] != rptr_r[PW]) &&
                 (wptr_r[PW-1:0] == rptr_r[PW-1:0]);
  assign empty = (wptr_r == rptr_r);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_r[rptr_r[PW-1:0]];
  assign push = in_valid_i && !full;
  assign pop  = out_ready_i && !empty;

  always_comb begin
    wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
    if (push) begin
      mem_r[wptr_r[PW-1:0]] <= in_data_i;
    end
  end

endmodule

// file: tb_top.sv
/*
  Self-checking bench for host_port_lanes in all strap modes.
  Assumes the design, its checker and the core model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        bus_mux_select_strap_i = 1'b0;
  logic        wide_bus_strap_i = 1'b0;
  logic        byte_order_strap_i = 1'b0;
  logic        host_ale_i = 1'b0;
  logic        host_req_i = 1'b0;
  logic        host_we_i = 1'b0;
  logic [7:0]  host_addr_i = 8'h00;
  logic [31:0] host_wdata_i = 32'h0;
  logic [31:0] host_rdata_o;
  logic        host_ack_o;
  logic        mux_mode_o;
  logic        wide_mode_o;
  logic        little_mode_o;
  logic [7:0]  reg_addr_o;
  logic [15:0] reg_wdata_o;
  logic        reg_we_o;
  logic        reg_re_o;
  logic [15:0] reg_rdata_i;
  logic        rx_byte_valid_i;
  logic        rx_byte_ready_o;
  logic [7:0]  rx_byte_i;
  logic [7:0]  bytes [$];
  logic [7:0]  a;
  logic [31:0] d;
  int          mismatches = 0;
  int          n_compared = 0;

  always #12.5 clk_i = ~clk_i;

  host_port_lanes dut_u (.*);
  core_model core_u (
    .clk_i           (clk_i),
    .reg_addr_i      (reg_addr_o),
    .reg_wdata_i     (reg_wdata_o),
    .reg_we_i        (reg_we_o),
    .reg_rdata_o     (reg_rdata_i),
    .rx_byte_valid_o (rx_byte_valid_i),
    .rx_byte_ready_i (rx_byte_ready_o),
    .rx_byte_o       (rx_byte_i)
  );

  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] pack(input int i, input logic w, l);
    logic [31:0] v;
    int          k;
    v = 32'h0;
    k = w ? 4 : 2;
    for (int j = 0; j < k; j++) begin
      if (l) v[8*j +: 8] = bytes[i*k+j];
      else v[8*(k-1-j) +: 8] = bytes[i*k+j];
    end
    return v;
  endfunction

  task automatic restart(input logic m, w, l);
    logic [2:0] s;
    @(negedge clk_i);
    srst_i = 1'b1;
    bus_mux_select_strap_i = m;
    wide_bus_strap_i = w;
    byte_order_strap_i = l;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    bus_mux_select_strap_i = ~m;
    wide_bus_strap_i = ~w;
    byte_order_strap_i = ~l;
    repeat (3) @(negedge clk_i);
    s = {mux_mode_o, wide_mode_o, little_mode_o};
    chk("modes", {29'h0, m, w, l}, {29'h0, s});
  endtask

  task automatic access(input logic w, input logic [7:0] ad,
                        input logic [31:0] dt);
    int n;
    n = 0;
    if (mux_mode_o === 1'b1) begin
      host_ale_i = 1'b1;
      host_wdata_i = {24'h0, ad};
      @(negedge clk_i);
      host_ale_i = 1'b0;
    end
    host_req_i = 1'b1;
    host_we_i = w;
    // Separate address lines carry a decoy in multiplexed mode.
    host_addr_i = (mux_mode_o === 1'b1) ? ~ad : ad;
    host_wdata_i = dt;
    @(negedge clk_i);
    host_req_i = 1'b0;
    while (host_ack_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    if (host_ack_o !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    @(negedge clk_i);
  endtask

  initial begin
    void'($urandom(44879));
    for (int t = 0; t < 8; t++) begin
      restart(t[2], t[1], t[0]);
      access(1'b0, 8'h00, $urandom);
      d = {16'h0000, host_port_pkg::DEVICE_NUMBER_DEF};
      chk("device number", d, host_rdata_o);
      // Writes to the device number and to the queue are acked and dropped.
      access(1'b1, host_port_pkg::DEVNUM_ADDR, $urandom);
      access(1'b1, host_port_pkg::QUEUE_ADDR, $urandom);
      access(1'b0, host_port_pkg::DEVNUM_ADDR, $urandom);
      chk("device number kept", d, host_rdata_o);
      repeat (3) begin
        a = 8'($urandom_range(253, 1));
        d = $urandom;
        access(1'b1, a, d);
        chk("core write", {16'h0, d[15:0]}, {16'h0, core_u.regs_r[a]});
        access(1'b0, a, ~d);
        chk("register read", {16'h0, d[15:0]}, host_rdata_o);
      end
      bytes.delete();
      repeat ((t[1] ? 4 : 2) * 5) begin
        // Multiplexed modes send the counting sequence 00, 01, 02 as a corner.
        bytes.push_back(t[2] ? 8'(bytes.size()) : 8'($urandom));
        core_u.push(bytes[$]);
      end
      repeat (60) @(negedge clk_i);
      chk("buffer full", 32'h0, {31'h0, rx_byte_ready_o});
      for (int i = 0; i < 5; i++) begin
        access(1'b0, 8'hFE, 32'h0);
        chk("queue word", pack(i, t[1], t[0]), host_rdata_o);
      end
      $display("mode test %0d done", t);
    end
    print_verdict();
  end
endmodule
